// ==== src/bus_event_pkg.sv ====
package bus_event_pkg;

  // Event mask field positions within the 16-bit mask.
  localparam int REQ_TYPE_LSB = 0;
  localparam int REQ_TYPE_W = 5;
  localparam int ALL_READ_BIT = 5;
  localparam int ALL_WRITE_BIT = 6;
  localparam int MEM_LSB = 7;
  localparam int MEM_W = 5;
  localparam int OWN_BIT = 13;
  localparam int OTHER_BIT = 14;
  localparam int PREFETCH_BIT = 15;
  localparam int MASK_W = 16;

  // Data activity mask bits.
  localparam int DATA_MASK_W = 6;
  localparam int DATA_READY_STROBE_DRV_BIT = 0;
  localparam int DATA_READY_STROBE_OWN_BIT = 1;
  localparam int DATA_READY_STROBE_OTHER_BIT = 2;
  localparam int DATA_BUS_BUSY_DRV_BIT = 3;
  localparam int DATA_BUS_BUSY_OWN_BIT = 4;
  localparam int DATA_BUS_BUSY_OTHER_BIT = 5;

  // Model threshold for the strict qualification expression.
  localparam logic [3:0] MODEL_STRICT_MIN = 4'h2;
  localparam int MODEL_W = 4;

  // Queue entry sizes in bytes.
  localparam int LINE_BYTES = 64;
  localparam int CHUNK_BYTES = 8;

  // Reset values.
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int COUNT_W = 16;

  // Memory type one-hot order: uc, wc, wt, wp, wb.
  typedef struct packed {
    logic [4:0] req_type;
    logic is_read;
    logic is_write;
    logic [4:0] mem_type;
    logic own;
    logic other;
    logic prefetch;
    logic full_line;
  } queue_entry_t;

  typedef struct packed {
    logic data_ready_strobe_drv;
    logic data_ready_strobe_own;
    logic data_ready_strobe_other;
    logic data_bus_busy_drv;
    logic data_bus_busy_own;
    logic data_bus_busy_other;
  } data_strobe_t;

endpackage : bus_event_pkg

// ==== src/queue_entry_match.sv ====
`timescale 1ns/1ns
`default_nettype none

module queue_entry_match (
  // Entry and controls
  input wire bus_event_pkg::queue_entry_t i_entry,
  input wire logic [15:0] i_mask_zero,
  input wire logic [15:0] i_mask_one,
  input wire logic [3:0] i_model,
  // Result
  output logic o_hit
);

  wire logic [15:0] mask;
  wire logic req_hit;
  wire logic rw_sel;
  wire logic rw_hit;
  wire logic mem_hit;
  wire logic src_hit;
  wire logic strict;

  assign mask = i_mask_zero & i_mask_one;
  assign req_hit = mask[bus_event_pkg::REQ_TYPE_LSB +: bus_event_pkg::REQ_TYPE_W]
                   == i_entry.req_type;
  assign rw_sel = mask[bus_event_pkg::ALL_READ_BIT] | mask[bus_event_pkg::ALL_WRITE_BIT];
  assign rw_hit = (mask[bus_event_pkg::ALL_READ_BIT] & i_entry.is_read)
                | (mask[bus_event_pkg::ALL_WRITE_BIT] & i_entry.is_write);
  assign mem_hit = rw_sel ? 1'b1
                 : |(mask[bus_event_pkg::MEM_LSB +: bus_event_pkg::MEM_W] & i_entry.mem_type);
  assign src_hit = ((mask[bus_event_pkg::OWN_BIT] & i_entry.own)
                 | (mask[bus_event_pkg::OTHER_BIT] & i_entry.other))
                 & (~i_entry.prefetch | mask[bus_event_pkg::PREFETCH_BIT]);
  assign strict = i_model >= bus_event_pkg::MODEL_STRICT_MIN;
  assign o_hit = strict ? (req_hit & rw_hit & mem_hit & src_hit)
               : (src_hit & (req_hit | rw_hit | (~rw_sel & mem_hit)));

endmodule : queue_entry_match

`default_nettype wire

// ==== src/bus_queue_event_qualify.sv ====
`timescale 1ns/1ns
`default_nettype none

module bus_queue_event_qualify (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Selector masks and model
  input wire logic [15:0] i_bus_event_selector_zero,
  input wire logic [15:0] i_bus_event_selector_one,
  input wire logic [5:0] i_data_mask,
  input wire logic [3:0] i_model,
  // Queue entry presented this cycle
  input wire logic i_entry_valid,
  input wire bus_event_pkg::queue_entry_t i_entry,
  input wire logic i_privilege_level,
  // Bus data strobes
  input wire bus_event_pkg::data_strobe_t i_strobe,
  // Results
  output logic o_queue_inc,
  output logic o_queue_line,
  output logic o_data_inc,
  output logic [15:0] o_queue_count,
  output logic [15:0] o_data_count
);

  // Qualifier result.
  wire logic entry_hit;
  wire logic entry_taken;

  // Next values of the queue occupancy flip-flops.
  wire logic next_queue_inc;
  wire logic next_queue_line;
  wire logic [15:0] next_queue_count;

  // Strobes in mask order and the next values of the data activity flip-flops.
  wire logic [5:0] strobe_vec;
  wire logic [5:0] strobe_sel;
  wire logic next_data_inc;
  wire logic [15:0] next_data_count;

  // Places each strobe at the bit that the data mask keeps for it.
  function automatic logic [5:0] strobe_bits(
    input bus_event_pkg::data_strobe_t strobe
  );
    logic [5:0] bits;
    bits = 6'h00;
    bits[bus_event_pkg::DATA_READY_STROBE_DRV_BIT] = strobe.data_ready_strobe_drv;
    bits[bus_event_pkg::DATA_READY_STROBE_OWN_BIT] = strobe.data_ready_strobe_own;
    bits[bus_event_pkg::DATA_READY_STROBE_OTHER_BIT] = strobe.data_ready_strobe_other;
    bits[bus_event_pkg::DATA_BUS_BUSY_DRV_BIT] = strobe.data_bus_busy_drv;
    bits[bus_event_pkg::DATA_BUS_BUSY_OWN_BIT] = strobe.data_bus_busy_own;
    bits[bus_event_pkg::DATA_BUS_BUSY_OTHER_BIT] = strobe.data_bus_busy_other;
    return bits;
  endfunction : strobe_bits

  // Counters wrap silently, so software must read them before a second wrap.
  function automatic logic [15:0] count_step(
    input logic [15:0] count,
    input logic bump
  );
    logic [15:0] stepped;
    stepped = count;
    if (bump) begin
      stepped = count + 16'h0001;
    end
    return stepped;
  endfunction : count_step

  queue_entry_match u_match (
    .i_entry(i_entry),
    .i_mask_zero(i_bus_event_selector_zero),
    .i_mask_one(i_bus_event_selector_one),
    .i_model(i_model),
    .o_hit(entry_hit)
  );

  // An entry counts only in the cycle in which the queue presents it.
  assign entry_taken = i_entry_valid & entry_hit;

  // The privilege input is deliberately unused by the qualifier.
  // no privilege filter
  assign next_queue_inc = entry_taken & (i_privilege_level | 1'b1);

  assign next_queue_line = next_queue_inc & i_entry.full_line;
  assign next_queue_count = count_step(o_queue_count, next_queue_inc);

  assign strobe_vec = strobe_bits(i_strobe);

  for (genvar i = 0; i < bus_event_pkg::DATA_MASK_W; i++) begin : g_strobe_sel
    assign strobe_sel[i] = strobe_vec[i] & i_data_mask[i];
  end

  // Several selected strobes in one cycle make a single step.
  // one step per cycle
  assign next_data_inc = |strobe_sel;
  assign next_data_count = count_step(o_data_count, next_data_inc);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_queue_inc <= 1'b0;
    end else begin
      o_queue_inc <= next_queue_inc;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_queue_line <= 1'b0;
    end else begin
      o_queue_line <= next_queue_line;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_queue_count <= bus_event_pkg::COUNT_RESET;
    end else begin
      o_queue_count <= next_queue_count;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_inc <= 1'b0;
    end else begin
      o_data_inc <= next_data_inc;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_count <= bus_event_pkg::COUNT_RESET;
    end else begin
      o_data_count <= next_data_count;
    end
  end

endmodule : bus_queue_event_qualify

`default_nettype wire

// ==== tb/bus_queue_event_qualify_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module bus_queue_event_qualify_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_bus_event_selector_zero,
  input wire logic [15:0] i_bus_event_selector_one,
  input wire logic [5:0] i_data_mask,
  input wire logic [3:0] i_model,
  input wire logic i_entry_valid,
  input wire logic i_privilege_level,
  input wire bus_event_pkg::queue_entry_t i_entry,
  input wire bus_event_pkg::data_strobe_t i_strobe,
  input wire logic o_queue_inc,
  input wire logic o_queue_line,
  input wire logic o_data_inc,
  input wire logic [15:0] o_data_count
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire [15:0] m = i_bus_event_selector_zero & i_bus_event_selector_one;
  wire rw = m[5] & i_entry.is_read | m[6] & i_entry.is_write;
  wire mem = |(m[11:7] & i_entry.mem_type) & !(m[5] | m[6]);
  wire src = (i_entry.own & m[13] | i_entry.other & m[14]) & (!i_entry.prefetch | m[15]);
  wire req = i_entry.req_type == m[4:0];
  wire strict = i_model >= bus_event_pkg::MODEL_STRICT_MIN;
  wire h = i_entry_valid & src & (strict ? req & rw : req | rw | mem);
  // Mask bit 0 pairs with the struct's top member, so the strobes are listed in reverse.
  wire [5:0] s = {i_strobe.data_bus_busy_other, i_strobe.data_bus_busy_own, i_strobe.data_bus_busy_drv,
    i_strobe.data_ready_strobe_other, i_strobe.data_ready_strobe_own, i_strobe.data_ready_strobe_drv};
  wire sel = |(s & i_data_mask);
  strict_hit_a: assert property (strict && h |=> o_queue_inc)
    else $error("strict hit missed");
  loose_hit_a: assert property (!strict && h |=> o_queue_inc)
    else $error("loose hit missed");
  no_hit_a: assert property (!h |=> !o_queue_inc)
    else $error("unqualified entry counted");
  priv_free_a: assert property (o_queue_inc |-> $past(h))
    else $error("count without qualified entry");
  priv_ignored_a: assert property (h && !i_privilege_level |=> o_queue_inc)
    else $error("low privilege entry dropped");
  line_size_a: assert property (h |=> o_queue_line == $past(i_entry.full_line))
    else $error("line size wrong");
  data_once_a: assert property (o_data_inc |-> o_data_count == 16'($past(o_data_count) + 1))
    else $error("data count step wrong");
  data_sel_a: assert property (sel |=> o_data_inc)
    else $error("selected strobe missed");
  data_quiet_a: assert property (!sel |=> !o_data_inc)
    else $error("unselected strobe counted");
  cover property (strict && h);
  cover property (!strict && h);
  cover property (o_data_inc);
  cover property (h && !i_privilege_level);
endmodule : bus_queue_event_qualify_checker
bind bus_queue_event_qualify bus_queue_event_qualify_checker u_checker (.*);
`default_nettype wire

// ==== tb/bus_agent_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bus_agent_model (
  input wire logic i_sys_clk,
  output var bus_event_pkg::queue_entry_t o_entry,
  output logic o_entry_valid,
  output var bus_event_pkg::data_strobe_t o_strobe
);
  initial begin
    o_entry = '0;
    o_entry_valid = 1'b0;
    o_strobe = '0;
  end
  // A released entry shows its inverse so stale values cannot look valid.
  task automatic put(input bus_event_pkg::queue_entry_t e, input logic [5:0] s);
    @(posedge i_sys_clk) #1;
    o_entry = e;
    o_entry_valid = 1'b1;
    o_strobe = s;
    @(posedge i_sys_clk) #1;
    o_entry = ~e;
    o_entry_valid = 1'b0;
    o_strobe = '0;
  endtask : put
endmodule : bus_agent_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk, rst_n, priv, valid, q_inc, q_line, d_inc;
  logic [15:0] msk, q_count, d_count;
  logic [5:0] dmask;
  logic [3:0] model;
  bus_event_pkg::queue_entry_t entry;
  bus_event_pkg::data_strobe_t strobe;
  int bad_count = 0, comparisons = 0, cycles = 0, eq = 0, ed = 0;
  bus_agent_model u_bus_agent_model (.i_sys_clk(sys_clk), .o_entry(entry),
    .o_entry_valid(valid), .o_strobe(strobe));
  bus_queue_event_qualify u_bus_queue_event_qualify (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_bus_event_selector_zero(msk), .i_bus_event_selector_one(msk), .i_data_mask(dmask),
    .i_model(model), .i_entry_valid(valid), .i_entry(entry), .i_privilege_level(priv),
    .i_strobe(strobe), .o_queue_inc(q_inc), .o_queue_line(q_line), .o_data_inc(d_inc),
    .o_queue_count(q_count), .o_data_count(d_count));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      wrap_up();
    end
  end
  task wrap_up;
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // level counting: every qualifying cycle counts, with no edge mode.
  task run(input bus_event_pkg::queue_entry_t e, input logic [5:0] s,
    input int dq, input int dd);
    u_bus_agent_model.put(e, s);
    eq += dq;
    ed += dd;
    comparisons++;
    if (q_count !== 16'(eq) || d_count !== 16'(ed)) begin
      $display("ERROR %0t q %h/%h d %h/%h", $time, q_count, 16'(eq), d_count, 16'(ed));
      bad_count++;
    end
  endtask : run
  task strict_mode;
    model = 4'h2;
    msk = 16'h2821;
    priv = 1'b0;
    run({5'h01, 2'b10, 5'h01, 4'b1001}, 6'h00, 1, 0);
    run({5'h01, 2'b01, 5'h01, 4'b1001}, 6'h00, 0, 0);
    priv = 1'b1;
    run({5'h01, 2'b10, 5'h01, 4'b1000}, 6'h00, 1, 0);
  endtask : strict_mode
  task loose_mode;
    model = 4'h1;
    msk = 16'h2801;
    run({5'h02, 2'b00, 5'h10, 4'b1000}, 6'h00, 1, 0);
    run({5'h02, 2'b00, 5'h10, 4'b0100}, 6'h00, 0, 0);
    msk = 16'h2821;
    run({5'h02, 2'b01, 5'h10, 4'b1000}, 6'h00, 0, 0);
  endtask : loose_mode
  task data_events;
    dmask = 6'h01;
    run('0, 6'h3f, 0, 1);
    run('0, 6'h02, 0, 0);
    dmask = 6'h10;
    run('0, 6'h02, 0, 1);
  endtask : data_events
  task reset_mid;
    rst_n = 1'b0;
    @(posedge sys_clk) #1;
    rst_n = 1'b1;
    eq = 0;
    ed = 0;
    run({5'h01, 2'b10, 5'h01, 4'b1000}, 6'h3f, 1, 1);
  endtask : reset_mid
  initial begin
    {rst_n, priv, dmask, model, msk} = '0;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    strict_mode();
    loose_mode();
    data_events();
    reset_mid();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
